// *** rtl/trs_seq.sv ***
`timescale 1ns/1ps
module trs_seq
    import trs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic tx_req,
    input wire logic cal_done,
    input wire logic retune_req,
    output logic pa_en,
    output logic ldo_ramp_en,
    output logic mod_en,
    output logic tx_off_done,
    output logic pll_ready
);
    logic [7:0] ramp_q, ramp_d;
    logic [4:0] soft_q, soft_d;
    logic [2:0] init_q, init_d;
    logic [7:0] rdata_q, rdata_d;
    trs_tx_t tx_q, tx_d;
    trs_pll_t pl_q, pl_d;
    logic pa_q, pa_d, ldo_q, ldo_d, mod_q, mod_d, off_q, off_d, rdy_q, rdy_d;
    logic ld_mod, ld_ldo, ld_pa, ld_pll;
    logic dn_mod, dn_ldo, dn_pa, dn_pll;
    logic [TRS_CNT_W-1:0] st_mod, st_ldo, st_pa, st_pll;
    logic [2:0] mod_code;
    logic [1:0] ldo_code, pa_code;
    logic tx_s1, tx_s2, cal_s1, cal_s2, rt_s1, rt_s2, cal_q, rt_q;

    assign mod_code = ramp_q[TRS_MOD_DLY_LSB +: 3];
    assign ldo_code = ramp_q[TRS_LDO_RAMP_LSB +: 2];
    assign pa_code = ramp_q[TRS_PA_RAMP_LSB +: 2];
    assign st_mod = TRS_CNT_W'(mod_code);
    assign st_ldo = TRS_CNT_W'(ldo_code) + 1'b1;
    assign st_pa = TRS_CNT_W'(pa_code) + 1'b1;

    trs_step_timer #(.STEP_CYC(TRS_MOD_STEP_US * TRS_US_CYC)) u_mod (
        .sys_clk(sys_clk), .rstn(rstn), .load(ld_mod), .steps(st_mod), .done(dn_mod));
    trs_step_timer #(.STEP_CYC(TRS_RAMP_STEP_US * TRS_US_CYC)) u_ldo (
        .sys_clk(sys_clk), .rstn(rstn), .load(ld_ldo), .steps(st_ldo), .done(dn_ldo));
    trs_step_timer #(.STEP_CYC(TRS_RAMP_STEP_US * TRS_US_CYC)) u_pa (
        .sys_clk(sys_clk), .rstn(rstn), .load(ld_pa), .steps(st_pa), .done(dn_pa));
    trs_step_timer #(.STEP_CYC(TRS_SETTLE_STEP_US * TRS_US_CYC)) u_pll (
        .sys_clk(sys_clk), .rstn(rstn), .load(ld_pll), .steps(st_pll), .done(dn_pll));

    // Control inputs come from the analogue side and are synchronised.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tx_s1 <= 1'b0;
            tx_s2 <= 1'b0;
            cal_s1 <= 1'b0;
            cal_s2 <= 1'b0;
            rt_s1 <= 1'b0;
            rt_s2 <= 1'b0;
            cal_q <= 1'b0;
            rt_q <= 1'b0;
        end else begin
            tx_s1 <= tx_req;
            tx_s2 <= tx_s1;
            cal_s1 <= cal_done;
            cal_s2 <= cal_s1;
            rt_s1 <= retune_req;
            rt_s2 <= rt_s1;
            cal_q <= cal_s2;
            rt_q <= rt_s2;
        end
    end

    always_comb begin
        ramp_d = ramp_q;
        soft_d = soft_q;
        init_d = init_q;
        rdata_d = 8'h00;
        if (reg_wr && reg_addr == TRS_RAMP_CTRL_OFS) begin
            ramp_d = reg_wdata;
        end
        if (reg_wr && reg_addr == TRS_SETTLE_OFS) begin
            soft_d = reg_wdata[TRS_SOFT_LSB +: 5];
            init_d = reg_wdata[TRS_INIT_LSB +: 3];
        end
        if (reg_rd && reg_addr == TRS_RAMP_CTRL_OFS) begin
            rdata_d = ramp_q;
        end else if (reg_rd && reg_addr == TRS_SETTLE_OFS) begin
            rdata_d = {soft_q, init_q};
        end
    end

    always_comb begin
        tx_d = tx_q;
        pa_d = pa_q;
        ldo_d = ldo_q;
        mod_d = mod_q;
        off_d = 1'b0;
        ld_mod = 1'b0;
        ld_ldo = 1'b0;
        ld_pa = 1'b0;
        unique case (tx_q)
            TRS_IDLE: begin
                if (tx_s2) begin
                    tx_d = TRS_RAMP;
                    pa_d = 1'b1;
                    ldo_d = 1'b1;
                    ld_mod = 1'b1;
                    ld_ldo = 1'b1;
                    ld_pa = 1'b1;
                end
            end
            TRS_RAMP: begin
                if (dn_ldo) begin
                    ldo_d = 1'b0;
                end
                if (dn_mod) begin
                    tx_d = TRS_MODDLY;
                end
            end
            TRS_MODDLY: begin
                if (!ldo_q || dn_ldo) begin
                    tx_d = TRS_ON;
                    mod_d = 1'b1;
                    ldo_d = 1'b0;
                end
            end
            TRS_ON: begin
                if (!tx_s2) begin
                    tx_d = TRS_DOWN;
                    mod_d = 1'b0;
                    ld_mod = 1'b1;
                end
            end
            TRS_DOWN: begin
                if (dn_mod) begin
                    tx_d = TRS_IDLE;
                    pa_d = 1'b0;
                    off_d = 1'b1;
                end
            end
            default: begin
                tx_d = TRS_IDLE;
                pa_d = 1'b0;
                ldo_d = 1'b0;
                mod_d = 1'b0;
            end
        endcase
    end

    always_comb begin
        pl_d = pl_q;
        rdy_d = rdy_q;
        ld_pll = 1'b0;
        st_pll = TRS_CNT_W'(init_q);
        unique case (pl_q)
            TRS_P_OFF, TRS_P_LOCK: begin
                if (cal_s2 && !cal_q) begin
                    pl_d = TRS_P_INIT;
                    rdy_d = 1'b0;
                    ld_pll = 1'b1;
                    st_pll = TRS_CNT_W'(init_q);
                end else if (rt_s2 && !rt_q && pl_q == TRS_P_LOCK) begin
                    pl_d = TRS_P_SOFT;
                    rdy_d = 1'b0;
                    ld_pll = 1'b1;
                    st_pll = TRS_CNT_W'(soft_q);
                end
            end
            TRS_P_INIT: begin
                if (dn_pll) begin
                    pl_d = TRS_P_SOFT;
                    ld_pll = 1'b1;
                    st_pll = TRS_CNT_W'(soft_q);
                end
            end
            TRS_P_SOFT: begin
                if (dn_pll) begin
                    pl_d = TRS_P_LOCK;
                    rdy_d = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ramp_q <= TRS_RAMP_CTRL_RST;
            soft_q <= TRS_SOFT_RST;
            init_q <= TRS_INIT_RST;
            rdata_q <= 8'h00;
            tx_q <= TRS_IDLE;
            pl_q <= TRS_P_OFF;
            pa_q <= 1'b0;
            ldo_q <= 1'b0;
            mod_q <= 1'b0;
            off_q <= 1'b0;
            rdy_q <= 1'b0;
        end else begin
            ramp_q <= ramp_d;
            soft_q <= soft_d;
            init_q <= init_d;
            rdata_q <= rdata_d;
            tx_q <= tx_d;
            pl_q <= pl_d;
            pa_q <= pa_d;
            ldo_q <= ldo_d;
            mod_q <= mod_d;
            off_q <= off_d;
            rdy_q <= rdy_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign pa_en = pa_q;
    assign ldo_ramp_en = ldo_q;
    assign mod_en = mod_q;
    assign tx_off_done = off_q;
    assign pll_ready = rdy_q;

    mod_after_pa_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        $rose(mod_q) |-> pa_q && $past(tx_q) == TRS_MODDLY) else $error("modulation without PA");
    pa_off_delay_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        $fell(pa_q) |-> $past(tx_q) == TRS_DOWN && $past(dn_mod)) else $error("PA dropped early");
    ldo_step_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        ld_ldo |=> ldo_q && pa_q) else $error("LDO ramp not started with PA");
    pa_step_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        ld_pa |-> st_pa inside {[8'h01:8'h04]}) else $error("bad PA steps");
    cold_chain_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        pl_q == TRS_P_INIT && dn_pll |=> pl_q == TRS_P_SOFT) else $error("cold start skipped soft");
    soft_load_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        ld_pll && pl_d == TRS_P_SOFT |-> st_pll == TRS_CNT_W'(soft_q)) else $error("bad soft load");
    init_load_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        ld_pll && pl_d == TRS_P_INIT |-> st_pll == TRS_CNT_W'(init_q)) else $error("bad init load");
    ready_expiry_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        $rose(rdy_q) |-> $past(dn_pll) && $past(pl_q) == TRS_P_SOFT) else $error("ready not on expiry");
    tx_up_c: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(mod_q));
    tx_down_c: cover property (@(posedge sys_clk) disable iff (!rstn) off_q);
    pll_lock_c: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(rdy_q));
    pa_ramp_c: cover property (@(posedge sys_clk) disable iff (!rstn) dn_pa);
endmodule

// *** rtl/trs_pkg.sv ***
package trs_pkg;
    localparam logic [7:0] TRS_RAMP_CTRL_OFS = 8'h52;
    localparam logic [7:0] TRS_SETTLE_OFS = 8'h53;
    localparam int TRS_MOD_DLY_LSB = 4;
    localparam int TRS_LDO_RAMP_LSB = 2;
    localparam int TRS_PA_RAMP_LSB = 0;
    localparam int TRS_SOFT_LSB = 3;
    localparam int TRS_INIT_LSB = 0;
    localparam logic [7:0] TRS_RAMP_CTRL_RST = 8'h00;
    localparam logic [4:0] TRS_SOFT_RST = 5'h0a;
    localparam logic [2:0] TRS_INIT_RST = 3'h2;
    localparam int TRS_CLK_MHZ = 250;
    localparam int TRS_US_CYC = TRS_CLK_MHZ;
    localparam int TRS_MOD_STEP_US = 4;
    localparam int TRS_RAMP_STEP_US = 5;
    localparam int TRS_SETTLE_STEP_US = 10;
    localparam int TRS_CNT_W = 8;
    typedef enum logic [2:0] {
        TRS_IDLE = 3'b000,
        TRS_RAMP = 3'b001,
        TRS_MODDLY = 3'b011,
        TRS_ON = 3'b010,
        TRS_DOWN = 3'b110
    } trs_tx_t;
    typedef enum logic [1:0] {
        TRS_P_OFF = 2'b00,
        TRS_P_INIT = 2'b01,
        TRS_P_SOFT = 2'b11,
        TRS_P_LOCK = 2'b10
    } trs_pll_t;
endpackage

// *** rtl/trs_step_timer.sv ***
`timescale 1ns/1ps
module trs_step_timer
    import trs_pkg::*;
#(
    parameter int STEP_CYC = 250
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic load,
    input wire logic [TRS_CNT_W-1:0] steps,
    output logic done
);
    localparam int PW = $clog2(STEP_CYC + 1);
    logic [PW-1:0] pre_q, pre_d;
    logic [TRS_CNT_W-1:0] cnt_q, cnt_d;
    logic run_q, run_d, done_q, done_d;
    always_comb begin
        pre_d = pre_q;
        cnt_d = cnt_q;
        run_d = run_q;
        done_d = 1'b0;
        if (load) begin
            pre_d = PW'(STEP_CYC - 1);
            cnt_d = steps;
            run_d = (steps != '0);
            done_d = (steps == '0);
        end else if (run_q) begin
            if (pre_q == '0) begin
                pre_d = PW'(STEP_CYC - 1);
                cnt_d = cnt_q - 1'b1;
                if (cnt_q == TRS_CNT_W'(1)) begin
                    run_d = 1'b0;
                    done_d = 1'b1;
                end
            end else begin
                pre_d = pre_q - 1'b1;
            end
        end
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pre_q <= '0;
            cnt_q <= '0;
            run_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            pre_q <= pre_d;
            cnt_q <= cnt_d;
            run_q <= run_d;
            done_q <= done_d;
        end
    end
    assign done = done_q;
endmodule

// *** sim/trs_far_model.sv ***
`timescale 1ns/1ps
// Far side model: calibration engine and channel controller of the synthesizer.
module trs_far_model (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic cal_go,
    input wire logic tune_go,
    output logic cal_done,
    output logic retune_req
);
    logic [2:0] tune_cnt_q;
    // Calibration done is a level that stays high once reached.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cal_done <= 1'b0;
            tune_cnt_q <= 3'h0;
        end else begin
            if (cal_go) begin
                cal_done <= 1'b1;
            end
            // A retune request is held long enough to pass the input synchroniser.
            if (tune_go) begin
                tune_cnt_q <= 3'h6;
            end else if (tune_cnt_q != 3'h0) begin
                tune_cnt_q <= tune_cnt_q - 3'h1;
            end
        end
    end
    assign retune_req = (tune_cnt_q != 3'h0);
endmodule

// *** sim/trs_seq_bench.sv ***
`timescale 1ns/1ps
module trs_seq_bench;
    import trs_pkg::*;
    logic sys_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, tx_req = 1'b0;
    logic cal_go = 1'b0, tune_go = 1'b0, cal_done, retune_req;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic pa_en, ldo_ramp_en, mod_en, tx_off_done, pll_ready;
    int bad_count = 0, n_compared = 0, n1, n2;
    always #2 sys_clk = ~sys_clk;
    trs_seq dut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_req(tx_req),
        .cal_done(cal_done), .retune_req(retune_req), .pa_en(pa_en), .ldo_ramp_en(ldo_ramp_en),
        .mod_en(mod_en), .tx_off_done(tx_off_done), .pll_ready(pll_ready));
    trs_far_model far (.sys_clk(sys_clk), .rstn(rstn), .cal_go(cal_go), .tune_go(tune_go),
        .cal_done(cal_done), .retune_req(retune_req));
    task automatic tally_and_finish();
        if (bad_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] seen);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Durations are accepted within a few cycles of synchroniser and register slack.
    task automatic cmp_t(input string what, input int exp, input int seen);
        n_compared++;
        if (seen < exp - 2 || seen > exp + 10) begin
            bad_count++;
            $display("mismatch %s expected %0d seen %0d", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        cmp8(what, exp, reg_rdata);
    endtask
    function automatic logic pick(input int sel);
        case (sel)
            0: return pa_en;
            1: return ldo_ramp_en;
            2: return mod_en;
            3: return tx_off_done;
            default: return pll_ready;
        endcase
    endfunction
    task automatic wait_for(input int sel, input logic val, input int limit, output int n);
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (pick(sel) !== val && n < limit);
    endtask
    task automatic tx_cycle(input logic [2:0] md, input logic [1:0] ldo);
        int e_mod, e_ldo;
        e_mod = md * TRS_MOD_STEP_US * TRS_US_CYC;
        e_ldo = (ldo + 1) * TRS_RAMP_STEP_US * TRS_US_CYC;
        wr(TRS_RAMP_CTRL_OFS, {1'b0, md, ldo, 2'b01});
        @(posedge sys_clk);
        tx_req <= 1'b1;
        wait_for(0, 1'b1, 20, n1);
        cmp8("ldo_with_pa", 8'h01, {7'h0, ldo_ramp_en});
        cmp8("mod_held", 8'h00, {7'h0, mod_en});
        wait_for(1, 1'b0, 9000, n1);
        cmp_t("ldo_ramp_len", e_ldo, n1);
        wait_for(2, 1'b1, 9000, n2);
        cmp_t("mod_delay", (e_mod > e_ldo) ? e_mod : e_ldo, n1 + n2);
        @(posedge sys_clk);
        tx_req <= 1'b0;
        wait_for(2, 1'b0, 20, n1);
        cmp8("pa_still_on", 8'h01, {7'h0, pa_en});
        wait_for(3, 1'b1, 9000, n1);
        cmp_t("ramp_down_delay", e_mod, n1);
        cmp8("pa_off", 8'h00, {7'h0, pa_en});
        @(posedge sys_clk);
        #1;
        cmp8("off_pulse_end", 8'h00, {7'h0, tx_off_done});
    endtask
    initial begin
        repeat (40000) @(posedge sys_clk);
        bad_count++;
        tally_and_finish();
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        rstn <= 1'b1;
        rd(TRS_RAMP_CTRL_OFS, TRS_RAMP_CTRL_RST, "ramp_ctrl_reset");
        rd(TRS_SETTLE_OFS, 8'h52, "settle_reset");
        rd(8'h54, 8'h00, "unmapped_read");
        wr(TRS_RAMP_CTRL_OFS, 8'hd6);
        wr(8'h54, 8'hff);
        rd(TRS_RAMP_CTRL_OFS, 8'hd6, "ramp_ctrl_rw");
        rd(8'h54, 8'h00, "unmapped_write");
        tx_cycle(3'h3, 2'h0);
        tx_cycle(3'h1, 2'h3);
        tx_cycle(3'h0, 2'h1);
        wr(TRS_SETTLE_OFS, 8'h11);
        rd(TRS_SETTLE_OFS, 8'h11, "settle_rw");
        // A retune before any lock must be ignored, so the cold start below still sees init plus soft.
        @(posedge sys_clk);
        tune_go <= 1'b1;
        @(posedge sys_clk);
        tune_go <= 1'b0;
        wait_for(4, 1'b1, 20, n1);
        cmp8("retune_unlocked", 8'h00, {7'h0, pll_ready});
        @(posedge sys_clk);
        cal_go <= 1'b1;
        @(posedge sys_clk);
        cal_go <= 1'b0;
        wait_for(4, 1'b1, 12000, n1);
        cmp_t("cold_settle", 3 * TRS_SETTLE_STEP_US * TRS_US_CYC, n1);
        @(posedge sys_clk);
        tune_go <= 1'b1;
        @(posedge sys_clk);
        tune_go <= 1'b0;
        wait_for(4, 1'b0, 20, n1);
        wait_for(4, 1'b1, 12000, n2);
        cmp_t("retune_settle", 2 * TRS_SETTLE_STEP_US * TRS_US_CYC, n1 + n2);
        tally_and_finish();
    end
endmodule
